// ---- verilog/sww_defines.vh ----
`ifndef SWW_DEFINES_VH
`define SWW_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define SWW_OFS_CTRL 8'h00
`define SWW_OFS_STATUS 8'h04
`define SWW_OFS_IEN 8'h08
`define SWW_OFS_IFLAG 8'h0C

// ****************************************
// field positions
// ****************************************
`define SWW_CTRL_GLBEN_BIT 0
`define SWW_ST_TMOUT_BIT 4
`define SWW_ST_PWRDN_BIT 3
`define SWW_ST_SLEEP_BIT 0

// ****************************************
// reset values and constants
// ****************************************
`define SWW_CTRL_RST 1'b0
`define SWW_IEN_RST 8'h00
`define SWW_PC_W 13
`define SWW_VECTOR_ADDR 13'h0004
`define SWW_QPHASES 4

`endif

// ---- verilog/sww_qdiv.v ----
`timescale 1ns/1ps
`include "sww_defines.vh"

// ****************************************
// instruction cycle divider
// ****************************************
module sww_qdiv #(
  parameter PHASES = `SWW_QPHASES
) (
  input wire pclk,
  input wire presetn,
  output reg cyc_stb_r
);

  reg [1:0] q_r; // oscillator phase within cycle
  reg [1:0] q_nxt;

  // next phase, wraps after last one
  always @* begin
    if (q_r == PHASES[1:0] - 2'h1) begin
      q_nxt = 2'h0;
    end else begin
      q_nxt = q_r + 2'h1;
    end
  end

  // strobe once every four clock periods
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 2'h0;
      cyc_stb_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      cyc_stb_r <= (q_r == PHASES[1:0] - 2'h1);
    end
  end

endmodule

// ---- verilog/sww_sleep_wake.v ----
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "sww_defines.vh"

// Operation
// - prefetch instruction at PC plus one
// - only enabled sources wake, ignoring global enable
// - global disabled: resume after power-down instruction
// - global enabled: next instruction, then vector
// - enabled flag pending: power-down becomes no-op
// - flag during power-down: complete, then wake
// - no-op leaves power-down flag set
// - instruction cycle is four clock periods
// - power-down flag set at reset, cleared executing
// - watchdog timeout wakes, clears timeout flag

module sww_sleep_wake #(
  parameter NSRC = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sleep_instr,
  input wire [`SWW_PC_W-1:0] pc_in,
  input wire [NSRC-1:0] irq_flags,
  input wire wdt_timeout,
  output reg sleeping_r,
  output reg prefetch_req_r,
  output reg [`SWW_PC_W-1:0] prefetch_addr_r,
  output reg wdt_clear_r,
  output reg resume_req_r,
  output reg vector_req_r,
  output reg [`SWW_PC_W-1:0] vector_addr_r,
  output reg nop_done_r,
  output reg cyc_stb_r
);

  // ****************************************
  // states, one-hot
  // ****************************************
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_EXEC = 5'h02;
  localparam [4:0] ST_SLEEP = 5'h04;
  localparam [4:0] ST_NEXT = 5'h08;
  localparam [4:0] ST_VECT = 5'h10;

  reg [4:0] state_r; // sequencer state
  reg [4:0] state_nxt;
  reg global_interrupt_enable_r; // software interrupt master switch
  reg [NSRC-1:0] ien_r; // per-source enables
  reg timeout_flag_n_r; // active low timeout flag
  reg powerdown_flag_n_r; // active low power-down flag
  reg sleep_pend_r; // power-down instruction awaiting cycle
  reg irq_wake_r; // woke by interrupt, not watchdog
  wire cyc_stb; // instruction cycle strobe
  wire irq_hit; // some enabled source flagged
  wire wr_en; // apb write access phase
  wire rd_en; // apb read access phase

  // ****************************************
  // instruction cycle timing
  // ****************************************
  sww_qdiv #(
    .PHASES(`SWW_QPHASES)
  ) u_qdiv (
    .pclk(pclk),
    .presetn(presetn),
    .cyc_stb_r(cyc_stb)
  );

  // wake condition looks at enables only, not the global enable
  assign irq_hit = |(irq_flags & ien_r);
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // ****************************************
  // apb slave, one wait state
  // ****************************************
  // pready pulses one cycle into the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (rd_en & ~pready) begin
        case (paddr)
          `SWW_OFS_CTRL: begin
            prdata[`SWW_CTRL_GLBEN_BIT] <= global_interrupt_enable_r;
          end
          `SWW_OFS_STATUS: begin
            prdata[`SWW_ST_TMOUT_BIT] <= timeout_flag_n_r;
            prdata[`SWW_ST_PWRDN_BIT] <= powerdown_flag_n_r;
            prdata[`SWW_ST_SLEEP_BIT] <= sleeping_r;
          end
          `SWW_OFS_IEN: begin
            prdata[NSRC-1:0] <= ien_r;
          end
          `SWW_OFS_IFLAG: begin
            prdata[NSRC-1:0] <= irq_flags;
          end
          default: begin
            pslverr <= 1'b1; // unmapped address
          end
        endcase
      end else if (wr_en & ~pready) begin
        case (paddr)
          `SWW_OFS_CTRL, `SWW_OFS_STATUS, `SWW_OFS_IEN: begin
            pslverr <= 1'b0;
          end
          default: begin
            pslverr <= 1'b1; // unmapped or IFLAG; STATUS writes are ignored without error
          end
        endcase
      end
    end
  end

  // writable controls, taken on the completing edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_interrupt_enable_r <= `SWW_CTRL_RST;
      ien_r <= {NSRC{1'b0}};
    end else if (wr_en & pready) begin
      if (paddr == `SWW_OFS_CTRL) begin
        global_interrupt_enable_r <= pwdata[`SWW_CTRL_GLBEN_BIT];
      end
      if (paddr == `SWW_OFS_IEN) begin
        ien_r <= pwdata[NSRC-1:0];
      end
    end
  end

  // ****************************************
  // sequencer next state
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        // pending enabled flag demotes to no-op
        if (cyc_stb & sleep_pend_r & ~irq_hit) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // always completes; wakes at once if flagged
        if (cyc_stb) begin
          if (irq_hit | wdt_timeout) begin
            state_nxt = ST_NEXT;
          end else begin
            state_nxt = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (irq_hit | wdt_timeout) begin
          state_nxt = ST_NEXT;
        end
      end
      ST_NEXT: begin
        // one cycle for the prefetched instruction
        if (cyc_stb) begin
          if (irq_wake_r & global_interrupt_enable_r) begin
            state_nxt = ST_VECT;
          end else begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_VECT: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // ****************************************
  // sequencer registers and outputs
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      sleep_pend_r <= 1'b0;
      irq_wake_r <= 1'b0;
      timeout_flag_n_r <= 1'b1;
      powerdown_flag_n_r <= 1'b1;
      sleeping_r <= 1'b0;
      prefetch_req_r <= 1'b0;
      prefetch_addr_r <= {`SWW_PC_W{1'b0}};
      wdt_clear_r <= 1'b0;
      resume_req_r <= 1'b0;
      vector_req_r <= 1'b0;
      vector_addr_r <= `SWW_VECTOR_ADDR;
      nop_done_r <= 1'b0;
      cyc_stb_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cyc_stb_r <= cyc_stb;
      prefetch_req_r <= 1'b0;
      wdt_clear_r <= 1'b0;
      resume_req_r <= 1'b0;
      vector_req_r <= 1'b0;
      nop_done_r <= 1'b0;
      sleeping_r <= (state_nxt == ST_SLEEP);
      // latch request until the next cycle strobe
      if (sleep_instr) begin
        sleep_pend_r <= 1'b1;
      end else if (cyc_stb & (state_r == ST_RUN)) begin
        sleep_pend_r <= 1'b0;
      end
      if (state_r == ST_RUN && cyc_stb && sleep_pend_r) begin
        if (irq_hit) begin
          nop_done_r <= 1'b1; // flags untouched
        end else begin
          prefetch_req_r <= 1'b1;
          prefetch_addr_r <= pc_in + `SWW_PC_W'h1;
        end
      end
      // completion of the power-down instruction
      if (state_r == ST_EXEC && cyc_stb) begin
        wdt_clear_r <= 1'b1;
        powerdown_flag_n_r <= 1'b0;
      end
      // timeout flag: set on completion, timeout clear wins
      if (wdt_timeout) begin
        timeout_flag_n_r <= 1'b0;
      end else if (state_r == ST_EXEC && cyc_stb) begin
        timeout_flag_n_r <= 1'b1;
      end
      if (state_r != ST_NEXT && state_nxt == ST_NEXT) begin
        irq_wake_r <= irq_hit & ~wdt_timeout;
        resume_req_r <= 1'b1; // continue at prefetched address
      end
      if (state_nxt == ST_VECT) begin
        vector_req_r <= 1'b1;
        vector_addr_r <= `SWW_VECTOR_ADDR;
      end
    end
  end

endmodule

// ---- verification/sww_checker.sv ----
`timescale 1ns/1ps
`include "sww_defines.vh"
// ****************************************
// power-down sequencing checker
// ****************************************
module sww_checker #(parameter NSRC = 8) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire sleep_instr,
  input wire [12:0] pc_in,
  input wire [NSRC-1:0] irq_flags,
  input wire wdt_timeout,
  input wire sleeping_r,
  input wire prefetch_req_r,
  input wire [12:0] prefetch_addr_r,
  input wire wdt_clear_r,
  input wire resume_req_r,
  input wire vector_req_r,
  input wire [12:0] vector_addr_r,
  input wire nop_done_r,
  input wire cyc_stb_r
);
  reg [12:0] pc_q; // pc of the pending power-down
  // capture pc as the request arrives
  always @(posedge pclk) if (sleep_instr) pc_q <= pc_in;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_gap; !cyc_stb_r [*3] ##1 cyc_stb_r; endsequence
  sequence s_clr; ##4 wdt_clear_r; endsequence
  property p_cyc; cyc_stb_r |=> s_gap; endproperty
  a_cyc: assert property (p_cyc) else $error("strobe gap");
  property p_pc; prefetch_req_r |-> prefetch_addr_r == pc_q + 1'b1;
  endproperty
  a_pc: assert property (p_pc) else $error("prefetch addr");
  property p_take;
    sleep_instr |-> ##[1:5] (prefetch_req_r || nop_done_r);
  endproperty
  a_take: assert property (p_take) else $error("no answer");
  property p_nop; nop_done_r |=> !wdt_clear_r [*4]; endproperty
  a_nop: assert property (p_nop) else $error("nop cleared");
  property p_clr; prefetch_req_r |-> s_clr; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_still;
    sleeping_r && !(|irq_flags) && !wdt_timeout |=> !resume_req_r;
  endproperty
  a_still: assert property (p_still) else $error("wake");
  property p_wdt;
    sleeping_r && wdt_timeout |=> resume_req_r && !sleeping_r;
  endproperty
  a_wdt: assert property (p_wdt) else $error("wdt wake");
  property p_vec;
    vector_req_r |-> vector_addr_r == `SWW_VECTOR_ADDR && !sleeping_r;
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_apb; psel && !penable |=> !pready ##1 pready; endproperty
  a_apb: assert property (p_apb) else $error("apb wait");
endmodule
bind sww_sleep_wake sww_checker #(.NSRC(NSRC)) chk_u (.*);

// ---- verification/sww_core_model.sv ----
`timescale 1ns/1ps
// ****************************************
// core pipeline and interrupt sources
// ****************************************
module sww_core_model (
  input wire pclk,
  input wire prefetch_req_r,
  input wire nop_done_r,
  output reg sleep_instr,
  output reg [12:0] pc_in,
  output reg [7:0] irq_flags,
  output reg wdt_timeout
);
  reg hold; // pc still owed to the block
  reg go; // power-down asked for by the bench
  reg [12:0] pc_go; // pc that goes with it
  initial begin
    sleep_instr = 1'b0;
    pc_in = 13'h0000;
    irq_flags = 8'h00;
    wdt_timeout = 1'b0;
    hold = 1'b0;
    go = 1'b0;
    pc_go = 13'h0000;
  end
  // program clears watchdog before, no-op slot after
  task do_sleep(input [12:0] pc);
    repeat (12) @(posedge pclk);
    pc_go <= pc;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  // one process owns pc: held while owed, else toggles
  always @(posedge pclk) begin
    sleep_instr <= go;
    if (go) begin
      pc_in <= pc_go;
      hold <= 1'b1;
    end else begin
      if (!hold) pc_in <= ~pc_in;
      if (prefetch_req_r || nop_done_r) hold <= 1'b0;
    end
  end
endmodule

// ---- verification/sww_sleep_wake_tb.sv ----
`timescale 1ns/1ps
`include "sww_defines.vh"
// ****************************************
// bench top
// ****************************************
module sww_sleep_wake_tb;
  reg pclk, presetn, psel, penable, pwrite; // bus master
  reg [7:0] paddr;
  reg [31:0] pwdata, rd; // rd: last read data
  reg er; // last error flag
  wire [31:0] prdata;
  wire pready, pslverr, sleep_instr, wdt_timeout, sleeping_r;
  wire prefetch_req_r, wdt_clear_r, resume_req_r, vector_req_r;
  wire nop_done_r, cyc_stb_r;
  wire [12:0] pc_in, prefetch_addr_r, vector_addr_r;
  wire [7:0] irq_flags;
  wire [4:0] ev; // core events watched by wt
  assign ev = {prefetch_req_r, vector_req_r, resume_req_r, sleeping_r,
    nop_done_r};
  int mismatches, checks;
  sww_sleep_wake dut_u (.*);
  sww_core_model core_u (.*);
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  task chk(input [31:0] s, input [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task finish_test;
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer, held until pready
  task apb(input w, input [7:0] a, input [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      mismatches++;
      finish_test;
    end
  endtask
  // bounded wait for one core event, looked at on the edge
  task wt(input int k);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge pclk);
      if (ev[k] === 1'b1) break;
    end
    if (n == 40) begin
      mismatches++;
      finish_test;
    end
  endtask
  // no vector in ten cycles
  task nv;
    reg v;
    v = 1'b0;
    repeat (10) begin
      @(posedge pclk);
      v = v | vector_req_r;
    end
    chk(v, 0);
  endtask
  // register map, reset values and bus errors
  task t_regs;
    apb(0, `SWW_OFS_STATUS, 0);
    chk(rd, 32'h18);
    apb(1, `SWW_OFS_IEN, 32'hA5);
    apb(0, `SWW_OFS_IEN, 0);
    chk(rd, 32'hA5);
    apb(1, `SWW_OFS_IFLAG, 1);
    chk(er, 1);
    apb(0, 8'h10, 0);
    chk(er, 1);
    apb(0, `SWW_OFS_CTRL, 0);
    chk(rd, 0);
  endtask
  // enabled flag already pending: power-down degrades
  task t_nop;
    apb(1, `SWW_OFS_IEN, 1);
    core_u.irq_flags <= 8'h01;
    core_u.do_sleep(13'h0123);
    wt(0);
    apb(0, `SWW_OFS_STATUS, 0);
    chk(rd, 32'h18);
    core_u.irq_flags <= 8'h00;
  endtask
  // interrupt wake with global enable clear
  task t_glb0;
    core_u.do_sleep(13'h1FFF);
    wt(1);
    apb(0, `SWW_OFS_STATUS, 0);
    chk(rd, 32'h11);
    core_u.irq_flags <= 8'h02;
    repeat (6) @(posedge pclk);
    chk(sleeping_r, 1);
    core_u.irq_flags <= 8'h03;
    wt(2);
    core_u.irq_flags <= 8'h00;
    nv;
    apb(0, `SWW_OFS_STATUS, 0);
    chk(rd, 32'h10);
  endtask
  // interrupt wake with global enable set
  task t_glb1;
    apb(1, `SWW_OFS_CTRL, 1);
    core_u.do_sleep(13'h0040);
    wt(1);
    chk(prefetch_addr_r, 13'h0041);
    core_u.irq_flags <= 8'h01;
    wt(2);
    core_u.irq_flags <= 8'h00;
    wt(3);
    chk(vector_addr_r, `SWW_VECTOR_ADDR);
  endtask
  // watchdog wake, no vector, timeout flag cleared
  task t_wdt;
    core_u.do_sleep(13'h0200);
    wt(1);
    @(posedge pclk);
    core_u.wdt_timeout <= 1'b1;
    @(posedge pclk);
    core_u.wdt_timeout <= 1'b0;
    wt(2);
    nv;
    apb(0, `SWW_OFS_STATUS, 0);
    chk(rd, 32'h00);
  endtask
  // enabled flag raised while the power-down instruction runs
  task t_late;
    core_u.do_sleep(13'h0300);
    wt(4);
    chk(prefetch_addr_r, 13'h0301);
    core_u.irq_flags <= 8'h01;
    wt(2);
    chk(wdt_clear_r, 1);
    chk(sleeping_r, 0);
    core_u.irq_flags <= 8'h00;
    wt(3);
    apb(0, `SWW_OFS_STATUS, 0);
    chk(rd, 32'h10);
  endtask
  // reset, scenarios, verdict
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    mismatches = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_nop;
    t_glb0;
    t_glb1;
    t_wdt;
    t_late;
    finish_test;
  end
endmodule
